// [logic/mrs_params.svh]
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH
`define MRS_CLK_MHZ        25
`define MRS_CLK_NS         40
`define MRS_T_WAIT_US      400
`define MRS_T_RAMP_US      700
`define MRS_T_PGFILT_US    1000
`define MRS_T_PGBLANK_US   2500
`define MRS_T_TRKDIS_US    4000
`define MRS_T_UVFILT_US    1000
`define MRS_T_UVEN_US      1200
`define MRS_T_PGDROP_NS    330
`define MRS_PGDROP_CYC     (`MRS_T_PGDROP_NS / `MRS_CLK_NS)
`define MRS_MINON_CYC      3'h4
`define MRS_TW             17
`define MRS_RAMP_STEPS     256
`define MRS_AW             8
`define MRS_ADDR_CTRL      8'h00
`define MRS_ADDR_STATUS    8'h04
`define MRS_CTRL_RST       32'h0000_0000
`define MRS_CTRL_FPWM      0
`define MRS_ST_STATE       0
`define MRS_ST_MODE        4
`define MRS_ST_OVFLAG      8
`define MRS_ST_OVLATCH     9
`define MRS_ST_UV          10
`define MRS_ST_PG          11
`define MRS_ST_SUSP        12
`define MRS_ST_SOFT        13
`define MRS_RESP_OKAY      2'h0
`define MRS_RESP_SLVERR    2'h2
`define MRS_MODE_500_NTRK  2'h3
`define MRS_MODE_670_NTRK  2'h2
`define MRS_MODE_670_TRK   2'h1
`define MRS_MODE_500_TRK   2'h0
`endif

// [logic/mrs_pkg.sv]
`default_nettype none
`include "mrs_params.svh"
package mrs_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_RAMP, ST_RUN, ST_DTRK}
		mrs_state_t;
	typedef struct packed {
		logic                   awvalid;
		logic [`MRS_AW-1:0]     awaddr;
		logic                   wvalid;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bready;
		logic                   arvalid;
		logic [`MRS_AW-1:0]     araddr;
		logic                   rready;
	} mrs_axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mrs_axi_rsp_t;
	typedef struct packed {
		logic overV;
		logic underV;
		logic inWin8;
		logic outWin16;
		logic aboveOob8;
		logic atZero;
		logic zeroCross;
		logic negLimit;
	} mrs_cmp_t;
	typedef struct packed {
		logic refOutEn;
		logic mainRailEn;
		logic termRefEn;
		logic termRailEn;
		logic termRailHiZ;
		logic mainDisch;
		logic termDisch;
		logic trackDisch;
	} mrs_rail_t;
	typedef struct packed {
		logic highSide;
		logic lowSide;
	} mrs_gate_t;
endpackage
`default_nettype wire

// [logic/mrs_sequencer.sv]
// Operation
// - both selects high turns main rail, termination reference and rail on
// - suspend low, soft-off high keeps main and reference, floats rail
// - both low turns everything off and discharges per latched mode, non-tracking with a fault latched
// - switching held off for 400 us after soft-off rises
// - soft-start ramps the reference over about 700 us
// - mode code latched at soft-off rise, sense current on, kept
// - mode code picks 500/670 kHz and tracking or non-tracking discharge
// - power-good rises after 1 ms inside the 8 percent window
// - power-good falls within 330 ns outside the 16 percent window
// - power-good blocked until 2.5 ms after soft-off rises
// - tracking discharge via termination path, non-tracking after 4 ms
// - non-tracking discharge uses dedicated discharge transistors
// - auto-skip cuts low-side drive at zero crossing
// - sense 20 percent high flags overvoltage, target zero, low side on
// - negative limit in overvoltage swaps to high side for minimum on
// - sense at zero after overvoltage latches low side, discharges term
// - sense below 68 percent for 1 ms latches undervoltage, gates low
// - undervoltage detection armed after 1.2 ms of operation
// - fault latches clear only on soft-off toggle or bias lockout; overvoltage latch re-sets if sense is at zero on the rise
// - 8 percent above target forces continuous PWM until back in range
// - bias lockout shuts all outputs but the register port off, non-latching
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`default_nettype none
`include "mrs_params.svh"
module mrs_sequencer #(
	parameter int WAIT_CYC    = `MRS_T_WAIT_US * `MRS_CLK_MHZ,
	parameter int RAMP_CYC    = `MRS_T_RAMP_US * `MRS_CLK_MHZ,
	parameter int PGFILT_CYC  = `MRS_T_PGFILT_US * `MRS_CLK_MHZ,
	parameter int PGBLANK_CYC = `MRS_T_PGBLANK_US * `MRS_CLK_MHZ,
	parameter int TRKDIS_CYC  = `MRS_T_TRKDIS_US * `MRS_CLK_MHZ,
	parameter int UVFILT_CYC  = `MRS_T_UVFILT_US * `MRS_CLK_MHZ,
	parameter int UVEN_CYC    = `MRS_T_UVEN_US * `MRS_CLK_MHZ
) (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  clkEn,
	input  wire logic                  suspendSelectIn,
	input  wire logic                  softOffSelectIn,
	input  wire logic                  biasUvloIn,
	input  wire logic [1:0]            modeCodeIn,
	input  wire mrs_pkg::mrs_cmp_t     cmpIn,
	input  wire logic                  pwmOnReq,
	input  wire mrs_pkg::mrs_axi_req_t axiReq,
	output mrs_pkg::mrs_axi_rsp_t      axiRsp,
	output mrs_pkg::mrs_rail_t         railOut,
	output mrs_pkg::mrs_gate_t         gateOut,
	output logic                       powerGoodOut,
	output logic                       modeSenseEn,
	output logic                       freqSel670,
	output logic [7:0]                 refRampOut
);
	import mrs_pkg::*;

	localparam int TW = `MRS_TW;
	localparam int STEP_CYC = RAMP_CYC / `MRS_RAMP_STEPS;
	localparam logic [TW-1:0] kWait    = TW'(WAIT_CYC);
	localparam logic [TW-1:0] kPgFilt  = TW'(PGFILT_CYC);
	localparam logic [TW-1:0] kPgBlank = TW'(PGBLANK_CYC);
	localparam logic [TW-1:0] kTrk     = TW'(TRKDIS_CYC);
	localparam logic [TW-1:0] kUvFilt  = TW'(UVFILT_CYC);
	localparam logic [TW-1:0] kUvEn    = TW'(WAIT_CYC + UVEN_CYC);
	localparam logic [TW-1:0] kStep    = TW'(STEP_CYC);

	////////////////////////////////////////////////////////////////////
	logic [13:0]   syncA_ff;
	logic [13:0]   syncB_ff;
	logic          suspS;
	logic          softS;
	logic          uvloS;
	logic [1:0]    modeS;
	mrs_cmp_t      cmpS;
	logic          pwmS;
	logic          rst;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncA_ff <= 14'h0000;
			syncB_ff <= 14'h0000;
		end else if (clkEn) begin
			syncA_ff <= {pwmOnReq, cmpIn, modeCodeIn, biasUvloIn,
				softOffSelectIn, suspendSelectIn};
			syncB_ff <= syncA_ff;
		end
	end
	assign {pwmS, cmpS, modeS, uvloS, softS, suspS} = syncB_ff;
	assign rst = srst | uvloS;

	////////////////////////////////////////////////////////////////////
	mrs_state_t    state_ff;
	mrs_state_t    nxt_state;
	logic          softPrev_ff;
	logic          softRise;
	logic [TW-1:0] stateTimer_ff;
	logic [TW-1:0] sinceEn_ff;
	logic [TW-1:0] stepCnt_ff;
	logic [7:0]    ramp_ff;
	logic [1:0]    mode_ff;
	logic          tracking;
	logic          running;
	logic          ovFlag_ff;
	logic          ovLatch_ff;
	logic          uvFlag_ff;
	logic [TW-1:0] uvCnt_ff;
	logic [TW-1:0] pgCnt_ff;
	logic [2:0]    minOn_ff;
	logic [31:0]   ctrl_ff;
	logic          contPwm;
	logic          faultDisch;

	assign softRise = softS & ~softPrev_ff;
	assign running  = (state_ff == ST_RAMP) || (state_ff == ST_RUN);

	always_ff @(posedge core_clk) begin
		if (rst)
			softPrev_ff <= 1'b0;
		else if (clkEn)
			softPrev_ff <= softS;
	end

	always_comb begin
		case (mode_ff)
			`MRS_MODE_500_NTRK: {tracking, freqSel670} = 2'b00;
			`MRS_MODE_670_NTRK: {tracking, freqSel670} = 2'b01;
			`MRS_MODE_670_TRK:  {tracking, freqSel670} = 2'b11;
			default:            {tracking, freqSel670} = 2'b10;
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: if (softRise)
				nxt_state = ST_WAIT;
			ST_WAIT, ST_RAMP, ST_RUN: begin
				if (!softS)
					nxt_state = (tracking && !ovLatch_ff && !uvFlag_ff)
						? ST_DTRK : ST_OFF;
				else if (state_ff == ST_WAIT && stateTimer_ff == kWait - 1)
					nxt_state = ST_RAMP;
				else if (state_ff == ST_RAMP && ramp_ff == 8'hff
					&& stepCnt_ff == kStep - 1)
					nxt_state = ST_RUN;
			end
			ST_DTRK: begin
				if (softRise)
					nxt_state = ST_WAIT;
				else if (stateTimer_ff == kTrk - 1)
					nxt_state = ST_OFF;
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff      <= ST_OFF;
			stateTimer_ff <= '0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				stateTimer_ff <= '0;
			else
				stateTimer_ff <= stateTimer_ff + 1'b1;
		end
	end

	// time since enable, saturates at the blanking count
	always_ff @(posedge core_clk) begin
		if (rst)
			sinceEn_ff <= '0;
		else if (clkEn) begin
			if (softRise || !softS)
				sinceEn_ff <= '0;
			else if (sinceEn_ff != kPgBlank)
				sinceEn_ff <= sinceEn_ff + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			mode_ff <= 2'h0;
		else if (clkEn && softRise)
			mode_ff <= modeS;
	end

	// stepped reference ramp; overvoltage forces target to zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ramp_ff    <= 8'h00;
			stepCnt_ff <= '0;
		end else if (clkEn) begin
			if (state_ff != ST_RAMP)
				stepCnt_ff <= '0;
			else if (stepCnt_ff == kStep - 1)
				stepCnt_ff <= '0;
			else
				stepCnt_ff <= stepCnt_ff + 1'b1;
			if (!running || ovFlag_ff)
				ramp_ff <= 8'h00;
			else if (state_ff == ST_RUN)
				ramp_ff <= 8'hff;
			else if (stepCnt_ff == kStep - 1 && ramp_ff != 8'hff)
				ramp_ff <= ramp_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// latches clear only on soft-off toggle or lockout; an ovLatch_ff set on the toggle edge wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ovFlag_ff  <= 1'b0;
			ovLatch_ff <= 1'b0;
		end else if (clkEn) begin
			if (softRise) begin
				ovFlag_ff  <= 1'b0;
				ovLatch_ff <= 1'b0;
			end
			if (running && cmpS.overV)
				ovFlag_ff <= 1'b1;
			if (ovFlag_ff && cmpS.atZero && softS)
				ovLatch_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			uvCnt_ff  <= '0;
			uvFlag_ff <= 1'b0;
		end else if (clkEn) begin
			if (!running || !cmpS.underV || ovFlag_ff || uvFlag_ff
				|| sinceEn_ff < kUvEn)
				uvCnt_ff <= '0;
			else
				uvCnt_ff <= uvCnt_ff + 1'b1;
			if (softRise)
				uvFlag_ff <= 1'b0;
			if (uvCnt_ff == kUvFilt - 1 && cmpS.underV && running)
				uvFlag_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			minOn_ff <= 3'h0;
		else if (clkEn) begin
			if (minOn_ff != 3'h0)
				minOn_ff <= minOn_ff - 1'b1;
			else if (ovFlag_ff && !ovLatch_ff && cmpS.negLimit)
				minOn_ff <= `MRS_MINON_CYC;
		end
	end

	assign contPwm = ctrl_ff[`MRS_CTRL_FPWM] | cmpS.aboveOob8;

	always_ff @(posedge core_clk) begin
		if (rst)
			gateOut <= '0;
		else if (clkEn) begin
			if (!running || uvFlag_ff)
				gateOut <= '0;
			else if (ovLatch_ff)
				gateOut <= 2'b01;
			else if (ovFlag_ff)
				gateOut <= (minOn_ff != 3'h0) ? 2'b10 : 2'b01;
			// zero-cross ends low side in skip
			else
				gateOut <= {pwmS, !pwmS && (contPwm || !cmpS.zeroCross)};
		end
	end

	////////////////////////////////////////////////////////////////////
	assign faultDisch = uvFlag_ff | ovLatch_ff;

	always_ff @(posedge core_clk) begin
		if (rst)
			railOut <= '0;
		else if (clkEn) begin
			railOut.refOutEn <= (state_ff != ST_OFF) && (state_ff != ST_DTRK);
			railOut.mainRailEn <= running && !faultDisch && !ovFlag_ff;
			railOut.termRefEn <= ((running || state_ff == ST_WAIT)
				&& !faultDisch) || state_ff == ST_DTRK;
			railOut.termRailEn <= (running && suspS && !faultDisch)
				|| state_ff == ST_DTRK;
			railOut.termRailHiZ <= (running || state_ff == ST_WAIT)
				&& !suspS && !faultDisch;
			railOut.mainDisch <= (state_ff == ST_OFF) || uvFlag_ff;
			railOut.termDisch <= (state_ff == ST_OFF) || faultDisch;
			railOut.trackDisch <= (state_ff == ST_DTRK);
		end
	end

	// assert after filter; drop at once
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pgCnt_ff     <= '0;
			powerGoodOut <= 1'b0;
		end else if (clkEn) begin
			// drop with the select too, on the same edge as the enable timer restarts
			if (!running || !softS || faultDisch || ovFlag_ff
				|| cmpS.outWin16)
				powerGoodOut <= 1'b0;
			else if (pgCnt_ff == kPgFilt - 1 && cmpS.inWin8)
				powerGoodOut <= 1'b1;
			if (powerGoodOut || !cmpS.inWin8 || !running
				|| sinceEn_ff != kPgBlank)
				pgCnt_ff <= '0;
			else
				pgCnt_ff <= pgCnt_ff + 1'b1;
		end
	end

	assign modeSenseEn = (state_ff == ST_WAIT);
	assign refRampOut  = ramp_ff;

	////////////////////////////////////////////////////////////////////
	// register slave: address and data taken in either order
	logic                awHeld_ff;
	logic                wHeld_ff;
	logic [`MRS_AW-1:0]  awAddr_ff;
	logic [31:0]         wData_ff;
	logic                wStrb0_ff;
	logic                bValid_ff;
	logic [1:0]          bResp_ff;
	logic                rValid_ff;
	logic [31:0]         rData_ff;
	logic [1:0]          rResp_ff;
	logic [31:0]         statusWord;

	assign statusWord = {18'h0_0000, softS, suspS, powerGoodOut,
		uvFlag_ff, ovLatch_ff, ovFlag_ff, 2'h0, mode_ff, 1'b0,
		state_ff};

	always_comb begin
		axiRsp.awready = clkEn && !awHeld_ff && !bValid_ff;
		axiRsp.wready  = clkEn && !wHeld_ff && !bValid_ff;
		axiRsp.bvalid  = bValid_ff;
		axiRsp.bresp   = bResp_ff;
		axiRsp.arready = clkEn && !rValid_ff;
		axiRsp.rvalid  = rValid_ff;
		axiRsp.rdata   = rData_ff;
		axiRsp.rresp   = rResp_ff;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff  <= 1'b0;
			awAddr_ff <= '0;
			wData_ff  <= 32'h0000_0000;
			wStrb0_ff <= 1'b0;
			bValid_ff <= 1'b0;
			bResp_ff  <= `MRS_RESP_OKAY;
			ctrl_ff   <= `MRS_CTRL_RST;
		end else if (clkEn) begin
			if (axiReq.awvalid && axiRsp.awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= axiReq.awaddr;
			end
			if (axiReq.wvalid && axiRsp.wready) begin
				wHeld_ff  <= 1'b1;
				wData_ff  <= axiReq.wdata;
				wStrb0_ff <= axiReq.wstrb[0];
			end
			if (awHeld_ff && wHeld_ff && !bValid_ff) begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
				bValid_ff <= 1'b1;
				if (awAddr_ff == `MRS_ADDR_CTRL) begin
					bResp_ff <= `MRS_RESP_OKAY;
					if (wStrb0_ff)
						ctrl_ff <= {31'h0000_0000, wData_ff[`MRS_CTRL_FPWM]};
				end else
					bResp_ff <= (awAddr_ff == `MRS_ADDR_STATUS)
						? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
			end else if (bValid_ff && axiReq.bready)
				bValid_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rValid_ff <= 1'b0;
			rData_ff  <= 32'h0000_0000;
			rResp_ff  <= `MRS_RESP_OKAY;
		end else if (clkEn) begin
			if (axiReq.arvalid && axiRsp.arready) begin
				rValid_ff <= 1'b1;
				rResp_ff  <= `MRS_RESP_OKAY;
				case (axiReq.araddr)
					`MRS_ADDR_CTRL:   rData_ff <= ctrl_ff;
					`MRS_ADDR_STATUS: rData_ff <= statusWord;
					default: begin
						rData_ff <= 32'h0000_0000;
						rResp_ff <= `MRS_RESP_SLVERR;
					end
				endcase
			end else if (rValid_ff && axiReq.rready)
				rValid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks skip the edge on which reset lets go: outputs not yet settled
	logic          rstSeen_ff;

	always_ff @(posedge core_clk) begin
		if (rst)
			rstSeen_ff <= 1'b1;
		else if (clkEn)
			rstSeen_ff <= 1'b0;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst || rstSeen_ff || !clkEn);

	chk_full_on: assert property (
		railOut.termRailEn && !railOut.trackDisch
		|-> railOut.mainRailEn || ovFlag_ff)
		else $error("termination rail on without main rail");
	chk_susp_hiz: assert property (
		railOut.termRailHiZ |-> railOut.termRefEn && !railOut.termRailEn
		&& !railOut.termDisch)
		else $error("suspend float state wrong");
	chk_off_disch: assert property (
		state_ff == ST_OFF && !softS |=> railOut.mainDisch
		&& railOut.termDisch && !railOut.refOutEn)
		else $error("off state not discharging");
	chk_wait_len: assert property (
		state_ff == ST_WAIT && nxt_state == ST_RAMP
		|-> stateTimer_ff == kWait - 1 ##1 gateOut == 2'b00)
		else $error("hold-off wait length wrong");
	chk_mode_hold: assert property (
		!softRise |=> $stable(mode_ff))
		else $error("mode latch changed outside enable");
	chk_pg_filter: assert property (
		$rose(powerGoodOut) |-> $past(pgCnt_ff) == kPgFilt - 1)
		else $error("power-good rose before filter time");
	chk_pg_drop: assert property (
		cmpS.outWin16 |=> !powerGoodOut)
		else $error("power-good held outside wide window");
	chk_pg_blank: assert property (
		powerGoodOut |-> sinceEn_ff == kPgBlank)
		else $error("power-good during blanking");
	chk_trk_len: assert property (
		state_ff == ST_DTRK && nxt_state == ST_OFF
		|-> stateTimer_ff == kTrk - 1)
		else $error("tracking discharge length wrong");
	chk_ov_drive: assert property (
		ovLatch_ff && running && !uvFlag_ff |=> gateOut == 2'b01)
		else $error("overvoltage latch drive wrong");
	chk_uv_gate: assert property (
		uvFlag_ff |=> gateOut == 2'b00 && railOut.mainDisch)
		else $error("undervoltage latch drive wrong");
	chk_uv_enable: assert property (
		$rose(uvFlag_ff) |-> sinceEn_ff >= kUvEn)
		else $error("undervoltage tripped too early");
	chk_latch_clear: assert property (
		$fell(ovFlag_ff) || $fell(uvFlag_ff) |-> $past(softRise))
		else $error("fault latch cleared without toggle");

	cov_pg_up:   cover property ($rose(powerGoodOut));
	cov_trk_end: cover property (state_ff == ST_DTRK ##1 state_ff == ST_OFF);
	cov_uv_trip: cover property ($rose(uvFlag_ff));
	cov_ov_zero: cover property ($rose(ovLatch_ff));
endmodule
`default_nettype wire

// [tb/mrs_platform_model.sv]
`default_nettype none
module mrs_platform_model (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic wantOn,
	input  wire logic wantSusp,
	input  wire logic wantBiasOff,
	output logic      suspendSelectIn,
	output logic      softOffSelectIn,
	output logic      biasUvloIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] biasOk_ff;
	assign biasUvloIn = wantBiasOff;
	////////////////////////////////////////////////////////////////////////
	// bias settles first
	always_ff @(posedge core_clk) begin
		if (srst || wantBiasOff)
			biasOk_ff <= 4'h0;
		else if (biasOk_ff != 4'hf)
			biasOk_ff <= biasOk_ff + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// soft-off only with bias up; dropping it recovers faults
	always_ff @(posedge core_clk) begin
		softOffSelectIn <= wantOn && biasOk_ff == 4'hf;
		suspendSelectIn <= wantOn && wantSusp;
	end
endmodule
`default_nettype wire

// [tb/test_mrs_sequencer.sv]
`default_nettype none
`include "mrs_params.svh"
module test_mrs_sequencer import mrs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WAITC = 20;
	localparam int RAMPC = 512;
	localparam int TRKC  = 50;
	logic         core_clk, srst, clkEn, pwmOnReq, powerGoodOut;
	logic         wantOn, wantSusp, wantBiasOff, modeSenseEn, freqSel670;
	logic         suspSel, softSel, biasUvlo;
	logic [1:0]   modeCodeIn, rs;
	logic [7:0]   refRampOut;
	logic [31:0]  rd;
	mrs_cmp_t     cmpIn;
	mrs_axi_req_t axiReq;
	mrs_axi_rsp_t axiRsp;
	mrs_rail_t    railOut;
	mrs_gate_t    gateOut;
	int           nErrors = 0;
	int           checks = 0;
	int           cyc = 0;

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	mrs_sequencer #(.WAIT_CYC(WAITC), .RAMP_CYC(RAMPC), .PGFILT_CYC(30),
		.PGBLANK_CYC(200), .TRKDIS_CYC(TRKC), .UVFILT_CYC(30),
		.UVEN_CYC(40)) i_mrs_sequencer (.core_clk(core_clk), .srst(srst),
		.clkEn(clkEn), .suspendSelectIn(suspSel),
		.softOffSelectIn(softSel), .biasUvloIn(biasUvlo),
		.modeCodeIn(modeCodeIn), .cmpIn(cmpIn), .pwmOnReq(pwmOnReq),
		.axiReq(axiReq), .axiRsp(axiRsp), .railOut(railOut),
		.gateOut(gateOut), .powerGoodOut(powerGoodOut),
		.modeSenseEn(modeSenseEn), .freqSel670(freqSel670),
		.refRampOut(refRampOut));

	mrs_platform_model i_mrs_platform_model (.core_clk(core_clk),
		.srst(srst), .wantOn(wantOn), .wantSusp(wantSusp),
		.wantBiasOff(wantBiasOff), .suspendSelectIn(suspSel),
		.softOffSelectIn(softSel), .biasUvloIn(biasUvlo));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task conclude();
		if (nErrors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// readies are combinational, so handshakes are judged before the edge
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		logic awHs, wHs, bHs;
		axiReq.awaddr <= a;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hf;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		do begin
			@(negedge core_clk);
			awHs = axiReq.awvalid && axiRsp.awready;
			wHs = axiReq.wvalid && axiRsp.wready;
			bHs = axiRsp.bvalid;
			rs = axiRsp.bresp;
			@(posedge core_clk);
			if (awHs)
				axiReq.awvalid <= 1'b0;
			if (wHs)
				axiReq.wvalid <= 1'b0;
		end while (!bHs);
		axiReq.bready <= 1'b0;
		tick(1);
	endtask

	task automatic axiRd(input logic [7:0] a);
		logic aHs, rHs;
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		do begin
			@(negedge core_clk);
			aHs = axiReq.arvalid && axiRsp.arready;
			rHs = axiRsp.rvalid;
			rd = axiRsp.rdata;
			rs = axiRsp.rresp;
			@(posedge core_clk);
			if (aHs)
				axiReq.arvalid <= 1'b0;
		end while (!rHs);
		axiReq.rready <= 1'b0;
		tick(1);
	endtask

	task automatic waitState(input mrs_state_t s);
		int n;
		n = 0;
		do begin
			axiRd(`MRS_ADDR_STATUS);
			n++;
		end while (rd[2:0] !== s && n < 300);
		check("state", rd[2:0], s);
	endtask

	task automatic startUp(input logic [1:0] m, input logic uvEarly);
		int t0;
		t0 = cyc;
		modeCodeIn <= m;
		cmpIn.inWin8 <= 1'b1;
		cmpIn.underV <= uvEarly;
		wantOn <= 1'b1;
		tick(6);
		check("senseEn", modeSenseEn, 1'h1);
		check("holdGates", gateOut, 2'h0);
		check("holdRamp", refRampOut, 8'h00);
		modeCodeIn <= ~m;
		tick(50);
		cmpIn.underV <= 1'b0;
		tick(100);
		check("pgBlank", powerGoodOut, 1'h0);
		waitState(ST_RUN);
		check("rampTime", cyc - t0 >= WAITC + RAMPC, 1'h1);
		check("rampTop", refRampOut, 8'hff);
		check("pgUp", powerGoodOut, 1'h1);
		check("modeLatch", rd[5:4], m);
		check("uvEarly", rd[10], 1'h0);
		check("freq", freqSel670, m == 2'h1 || m == 2'h2);
	endtask

	task automatic shutDown(input logic [1:0] m);
		wantOn <= 1'b0;
		tick(6);
		if (m < 2'h2) begin
			check("trkDis", railOut.trackDisch, 1'h1);
			check("trkFollow", railOut.termRailEn, 1'h1);
			tick(40);
			check("trkHold", railOut.trackDisch, 1'h1);
			tick(14);
		end
		check("offRails", railOut, 8'h06);
	endtask

	////////////////////////////////////////////////////////////////////////
	task scnRegs();
		check("rstRails", railOut, 8'h06);
		axiRd(`MRS_ADDR_CTRL);
		check("ctrlRst", rd, `MRS_CTRL_RST);
		axiRd(8'h08);
		check("unmapResp", rs, `MRS_RESP_SLVERR);
		check("unmapData", rd, 32'h0000_0000);
		axiWr(`MRS_ADDR_STATUS, 32'hffff_ffff);
		check("roResp", rs, `MRS_RESP_OKAY);
		axiWr(`MRS_ADDR_CTRL, 32'h0000_0001);
		axiRd(`MRS_ADDR_CTRL);
		check("ctrlRw", rd, 32'h0000_0001);
		axiWr(`MRS_ADDR_CTRL, 32'h0000_0000);
		clkEn <= 1'b0;
		tick(3);
		check("frzAw", axiRsp.awready, 1'h0);
		check("frzAr", axiRsp.arready, 1'h0);
		clkEn <= 1'b1;
	endtask

	task automatic scnStates();
		int n;
		startUp(2'h1, 1'b1);
		check("fullOn", railOut, 8'hf0);
		cmpIn.inWin8 <= 1'b0;
		cmpIn.outWin16 <= 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (powerGoodOut !== 1'b0 && n < 20);
		check("pgDrop", n <= 3 + `MRS_PGDROP_CYC, 1'h1);
		cmpIn.outWin16 <= 1'b0;
		cmpIn.inWin8 <= 1'b1;
		tick(25);
		check("pgFilt", powerGoodOut, 1'h0);
		tick(15);
		check("pgBack", powerGoodOut, 1'h1);
		wantSusp <= 1'b0;
		tick(6);
		check("suspend", railOut, 8'he8);
		wantSusp <= 1'b1;
		cmpIn.zeroCross <= 1'b1;
		tick(6);
		check("skipLow", gateOut.lowSide, 1'h0);
		cmpIn.aboveOob8 <= 1'b1;
		tick(6);
		check("oobPwm", gateOut.lowSide, 1'h1);
		cmpIn.aboveOob8 <= 1'b0;
		tick(6);
		check("oobEnd", gateOut.lowSide, 1'h0);
		pwmOnReq <= 1'b1;
		tick(6);
		check("pwmHigh", gateOut, 2'h2);
		pwmOnReq <= 1'b0;
		axiWr(`MRS_ADDR_CTRL, 32'h0000_0001);
		tick(4);
		check("forcePwm", gateOut.lowSide, 1'h1);
		axiWr(`MRS_ADDR_CTRL, 32'h0000_0000);
		cmpIn.zeroCross <= 1'b0;
		shutDown(2'h1);
	endtask

	task scnModes();
		for (int m = 0; m < 4; m++) begin
			startUp(m[1:0], 1'b0);
			shutDown(m[1:0]);
		end
	endtask

	task scnUnder();
		startUp(2'h3, 1'b0);
		cmpIn.underV <= 1'b1;
		tick(20);
		check("uvFilt", gateOut, 2'h1);
		tick(30);
		check("uvGates", gateOut, 2'h0);
		check("uvDisch", railOut.mainDisch, 1'h1);
		cmpIn.underV <= 1'b0;
		tick(10);
		axiRd(`MRS_ADDR_STATUS);
		check("uvHeld", rd[10], 1'h1);
		wantOn <= 1'b0;
		tick(6);
		startUp(2'h3, 1'b0);
	endtask

	task automatic scnOver();
		int n;
		cmpIn.overV <= 1'b1;
		tick(6);
		check("ovGates", gateOut, 2'h1);
		check("ovMain", railOut.mainRailEn, 1'h0);
		cmpIn.negLimit <= 1'b1;
		tick(1);
		cmpIn.negLimit <= 1'b0;
		n = 0;
		repeat (12) begin
			@(negedge core_clk);
			n += gateOut.highSide;
		end
		check("minOn", n, 32'h0000_0004);
		tick(1);
		cmpIn.atZero <= 1'b1;
		tick(6);
		check("zeroGates", gateOut, 2'h1);
		check("zeroTerm", railOut.termDisch, 1'h1);
		axiRd(`MRS_ADDR_STATUS);
		check("zeroLatch", rd[9:8], 2'h3);
		cmpIn.overV <= 1'b0;
		cmpIn.atZero <= 1'b0;
		wantOn <= 1'b0;
		tick(6);
	endtask

	task scnBias();
		startUp(2'h2, 1'b0);
		wantBiasOff <= 1'b1;
		tick(6);
		check("uvloRails", railOut, 8'h00);
		check("uvloGates", gateOut, 2'h0);
		check("uvloPg", powerGoodOut, 1'h0);
		axiRd(`MRS_ADDR_STATUS);
		check("uvloMode", rd[5:0], 6'h00);
		wantBiasOff <= 1'b0;
		waitState(ST_RUN);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		clkEn = 1'b1;
		pwmOnReq = 1'b0;
		wantOn = 1'b0;
		wantSusp = 1'b1;
		wantBiasOff = 1'b0;
		modeCodeIn = 2'h0;
		cmpIn = '0;
		axiReq = '0;
		tick(12);
		srst <= 1'b0;
		tick(4);
		scnRegs();
		scnStates();
		scnModes();
		scnUnder();
		scnOver();
		scnBias();
		conclude();
	end

	initial begin
		tick(60000);
		nErrors++;
		conclude();
	end
endmodule
`default_nettype wire
